// File: verilog/nps_ecc_top.sv
// NAND page SEC-DED code engine with register port
//
// Function
// - Correct any single-bit page error, detect random two-bit errors.
// - Treat page as 8-bit or 16-bit words per memory width.
// - Page size field selects 512/1024/2048/4096 main-area words, codes 00..11.
// - Start computing on page read 00h or page program 80h.
// - Results valid at end of main area, frozen until next start; on a read the syndrome replaces them after the spare words.
// - After stored code is read back, detect errors and set flags.
// - Zero syndrome reports no error, all flags clear.
// - Single data error sets recoverable flag, reports word and bit.
// - One corrupt stored code bit sets the code-area flag.
// - Several errors set the multiple-error flag.
// - Command or software reset clears status and parity registers.
// - Generate a 32-bit Hamming-style SEC-DED code per page.
// - Code splits into row parity and column parity terms.
// - Word parity goes to P or P' term by each index bit.
// - Highest row term follows page size, P2048 up to P16384.
// - Control bit one clears parity results, zero has no effect.
// - Word and bit positions meaningful only after a single error.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

module nps_ecc_top #(
  parameter int IDX_W = 12
) (
  input wire logic clk_sys, // System clock, 25 MHz
  input wire logic rst, // Synchronous reset, high
  input wire logic [4:0] regAddr, // Register byte address
  input wire logic [31:0] regWdata, // Register write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [31:0] regRdata, // Read data, cycle after strobe
  input wire logic nandCmdStb, // Command cycle on NAND bus
  input wire logic nandAddrStb, // Address cycle on NAND bus
  input wire logic nandDataStb, // Data word cycle on NAND bus
  input wire logic [15:0] nandBus, // NAND bus value
  input wire logic nandWide16 // Memory is 16-bit organised
);

  // ****************************************************************
  // State and registers
  // ****************************************************************
  nps_pkg::nps_state_e state_reg, state_next;
  logic isRead_reg;
  logic [1:0] mode_reg;
  logic [2:0] status_reg;
  logic [15:0] parity_reg;
  logic [15:0] nparity_reg;
  logic [IDX_W-1:0] wordIdx_reg;
  logic [1:0] spareCnt_reg;
  logic [31:0] stored_reg;
  logic endPend_reg;
  logic [31:0] rdata_reg;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire logic wrCtrl, wrMode, swReset;
  assign wrCtrl = regWr && (regAddr == nps_pkg::OFS_CTRL);
  assign wrMode = regWr && (regAddr == nps_pkg::OFS_MODE);
  assign swReset = wrCtrl && regWdata[nps_pkg::CTRL_RST_BIT];

  // ****************************************************************
  // NAND traffic decode
  // ****************************************************************
  // Only the two page-opening commands start a page; confirm codes
  // such as program-confirm pass by without effect.
  wire logic cmdRead, cmdProg, cmdStart;
  assign cmdRead = nandCmdStb && (nandBus[7:0] == nps_pkg::CMD_PAGE_READ);
  assign cmdProg = nandCmdStb &&
    (nandBus[7:0] == nps_pkg::CMD_PAGE_PROGRAM);
  assign cmdStart = cmdRead || cmdProg;

  // Upper byte ignored for 8-bit parts
  wire logic [15:0] wordData;
  assign wordData = nandWide16 ? nandBus : {8'h00, nandBus[7:0]};

  // Last index equals the used row-bit mask: 512 << size minus one
  wire logic [IDX_W-1:0] lastIdx;
  assign lastIdx = IDX_W'((nps_pkg::PAGE_BASE_WORDS << mode_reg)
    - 13'h0001);

  wire logic mainWord, lastWord, spareWord, lastSpare;
  assign mainWord = (state_reg == nps_pkg::ST_DATA) && nandDataStb;
  assign lastWord = mainWord && (wordIdx_reg == lastIdx);
  assign spareWord = (state_reg == nps_pkg::ST_SPARE) && nandDataStb;
  assign lastSpare = spareWord && (spareCnt_reg == (nandWide16 ?
    nps_pkg::SPARE_LAST_16 : nps_pkg::SPARE_LAST_8));

  // ****************************************************************
  // Parity accumulator
  // ****************************************************************
  logic [IDX_W-1:0] rowPar, rowParN;
  logic [3:0] colPar, colParN;

  nps_parity_acc #(
    .IDX_W(IDX_W),
    .COL_W(4)
  ) uAcc (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(cmdStart || swReset),
    .wordEn(mainWord),
    .wordData(wordData),
    .wordIdx(wordIdx_reg),
    .rowPar(rowPar),
    .rowParN(rowParN),
    .colPar(colPar),
    .colParN(colParN)
  );

  // ****************************************************************
  // Computed code and syndrome
  // ****************************************************************
  // Row bits above the page's index width and the byte column of
  // 8-bit parts carry no information and are masked out.
  wire logic [3:0] colMask;
  wire logic [15:0] codeMask, calcP, calcN;
  assign colMask = nandWide16 ? nps_pkg::COL_MASK_16 :
    nps_pkg::COL_MASK_8;
  assign codeMask = {lastIdx, colMask};
  assign calcP = {rowPar, colPar} & codeMask;
  assign calcN = {rowParN, colParN} & codeMask;

  // Stored code as it stands once the last spare word lands
  wire logic [31:0] storedCode;
  assign storedCode = nandWide16 ? {nandBus, stored_reg[31:16]} :
    {nandBus[7:0], stored_reg[31:8]};

  wire logic [15:0] synP, synN, synOr, synOrDec;
  assign synP = (calcP ^ storedCode[15:0]) & codeMask;
  assign synN = (calcN ^ storedCode[31:16]) & codeMask;
  assign synOr = synP | synN;
  assign synOrDec = synOr - 16'h0001;

  // Classification: P and P' syndromes complement for a data bit
  wire logic detect, noErr, dataErr, codeErr, multiErr;
  assign detect = lastSpare && isRead_reg;
  assign noErr = (synOr == 16'h0000);
  assign dataErr = ((synP ^ synN) == codeMask);
  assign codeErr = !noErr && ((synOr & synOrDec) == 16'h0000);
  assign multiErr = !noErr && !dataErr && !codeErr;

  wire logic [2:0] detFlags;
  assign detFlags = dataErr ? 3'h1 : (codeErr ? 3'h2 :
    (multiErr ? 3'h5 : 3'h0));

  // ****************************************************************
  // Page sequencer
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      nps_pkg::ST_IDLE: begin
      end
      nps_pkg::ST_ARMED: begin
        if (nandAddrStb) begin
          state_next = nps_pkg::ST_DATA;
        end
      end
      nps_pkg::ST_DATA: begin
        if (lastWord) begin
          state_next = isRead_reg ? nps_pkg::ST_SPARE :
            nps_pkg::ST_LOCKED;
        end
      end
      nps_pkg::ST_SPARE: begin
        if (lastSpare) begin
          state_next = nps_pkg::ST_LOCKED;
        end
      end
      nps_pkg::ST_LOCKED: begin
      end
      default: begin
        state_next = nps_pkg::ST_IDLE;
      end
    endcase
    if (cmdStart) begin
      state_next = nps_pkg::ST_ARMED;
    end else if (swReset) begin
      state_next = nps_pkg::ST_IDLE;
    end
  end

  // State, direction and counters
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= nps_pkg::ST_IDLE;
      isRead_reg <= 1'b0;
      wordIdx_reg <= '0;
      spareCnt_reg <= 2'h0;
      endPend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      endPend_reg <= lastWord;
      if (cmdStart) begin
        isRead_reg <= cmdRead;
      end
      if (cmdStart || swReset) begin
        wordIdx_reg <= '0;
        spareCnt_reg <= 2'h0;
      end else if (mainWord) begin
        wordIdx_reg <= wordIdx_reg + 1'b1;
      end else if (spareWord) begin
        spareCnt_reg <= spareCnt_reg + 2'h1;
      end
    end
  end

  // Stored code capture, low word first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stored_reg <= 32'h0000_0000;
    end else if (spareWord) begin
      stored_reg <= storedCode;
    end
  end

  // ****************************************************************
  // Result registers
  // ****************************************************************
  // A detection outranks a same-cycle clear so an outcome is never
  // dropped; in practice both cannot share one bus cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_reg <= nps_pkg::STATUS_RESET;
      parity_reg <= nps_pkg::PARITY_RESET;
      nparity_reg <= nps_pkg::PARITY_RESET;
    end else if (detect) begin
      status_reg <= detFlags;
      parity_reg <= synP;
      nparity_reg <= synN;
    end else if (cmdStart || swReset) begin
      status_reg <= nps_pkg::STATUS_RESET;
      parity_reg <= nps_pkg::PARITY_RESET;
      nparity_reg <= nps_pkg::PARITY_RESET;
    end else if (endPend_reg) begin
      parity_reg <= calcP;
      nparity_reg <= calcN;
    end
  end

  // Mode register; size change mid-page is the user's hazard
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_reg <= nps_pkg::MODE_RESET;
    end else if (wrMode) begin
      mode_reg <= regWdata[1:0];
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  wire logic [31:0] rdMux;
  assign rdMux =
    (regAddr == nps_pkg::OFS_MODE) ? {30'h0, mode_reg} :
    (regAddr == nps_pkg::OFS_STATUS) ? {29'h0, status_reg} :
    (regAddr == nps_pkg::OFS_PARITY) ? {16'h0, parity_reg} :
    (regAddr == nps_pkg::OFS_NPARITY) ? {16'h0, nparity_reg} :
    32'h0000_0000;

  // Write-only control and unmapped addresses read as zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (regRd) begin
      rdata_reg <= rdMux;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end
  assign regRdata = rdata_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence sStart;
    cmdStart && !detect;
  endsequence

  sequence sCleared;
    status_reg == 3'h0 && parity_reg == 16'h0 && nparity_reg == 16'h0;
  endsequence

  chk_cmd_clears: assert property (@(posedge clk_sys) disable iff (rst)
    sStart |=> sCleared)
    else $error("command did not clear results");

  chk_swrst_clears: assert property (@(posedge clk_sys)
    disable iff (rst)
    swReset && !detect |=> parity_reg == 16'h0 && nparity_reg == 16'h0)
    else $error("software reset did not clear parity");

  chk_start_arms: assert property (@(posedge clk_sys) disable iff (rst)
    cmdStart ##1 nandAddrStb && !cmdStart && !swReset
    |=> state_reg == nps_pkg::ST_DATA)
    else $error("page start not armed by command and address");

  chk_result_frozen: assert property (@(posedge clk_sys)
    disable iff (rst)
    state_reg == nps_pkg::ST_LOCKED && !endPend_reg && !cmdStart && !swReset
    |=> $stable(parity_reg) && $stable(nparity_reg))
    else $error("locked parity changed");

  chk_end_locks: assert property (@(posedge clk_sys) disable iff (rst)
    lastWord && !cmdStart && !swReset && !isRead_reg
    |=> state_reg == nps_pkg::ST_LOCKED ##1 parity_reg == $past(calcP))
    else $error("write parity not latched at end of main area");

  chk_no_error: assert property (@(posedge clk_sys) disable iff (rst)
    detect && noErr |=> status_reg == 3'h0 && parity_reg == 16'h0)
    else $error("clean page reported an error");

  chk_single_flag: assert property (@(posedge clk_sys) disable iff (rst)
    detect && dataErr |=> status_reg == 3'h1 && parity_reg == $past(synP))
    else $error("single error not reported");

  chk_code_flag: assert property (@(posedge clk_sys) disable iff (rst)
    detect && codeErr |=> status_reg == 3'h2)
    else $error("code-area error not reported");

  chk_multi_flag: assert property (@(posedge clk_sys) disable iff (rst)
    detect && multiErr |=> status_reg[nps_pkg::STAT_MULTI_BIT])
    else $error("multiple error not reported");

  chk_page_size: assert property (@(posedge clk_sys) disable iff (rst)
    13'(lastIdx) == ((mode_reg == 2'h0) ? 13'h01ff :
    (mode_reg == 2'h1) ? 13'h03ff : (mode_reg == 2'h2) ? 13'h07ff : 13'h0fff))
    else $error("page length does not follow size field");

endmodule

// File: verilog/nps_pkg.sv
// Shared constants for the NAND page SEC-DED code engine
package nps_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam int REG_ADDR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_MODE = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_PARITY = 5'h0c;
  localparam logic [4:0] OFS_NPARITY = 5'h10;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_RST_BIT = 0;
  localparam int STAT_RECOV_BIT = 0;
  localparam int STAT_CODE_BIT = 1;
  localparam int STAT_MULTI_BIT = 2;
  localparam int PR_BIT_IDX_W = 4;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [15:0] PARITY_RESET = 16'h0000;

  // ****************************************************************
  // NAND commands and page geometry
  // ****************************************************************
  localparam logic [7:0] CMD_PAGE_READ = 8'h00;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h80;
  localparam logic [12:0] PAGE_BASE_WORDS = 13'h0200;
  localparam logic [1:0] SPARE_LAST_8 = 2'h3;
  localparam logic [1:0] SPARE_LAST_16 = 2'h1;
  localparam logic [3:0] COL_MASK_8 = 4'h7;
  localparam logic [3:0] COL_MASK_16 = 4'hf;

  // Column groups: bits whose position has bit k set
  localparam logic [15:0] COL_SEL0 = 16'haaaa;
  localparam logic [15:0] COL_SEL1 = 16'hcccc;
  localparam logic [15:0] COL_SEL2 = 16'hf0f0;
  localparam logic [15:0] COL_SEL3 = 16'hff00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_DATA,
    ST_SPARE,
    ST_LOCKED
  } nps_state_e;

endpackage

// File: verilog/nps_parity_acc.sv
// Running row and column parity accumulator for one page
`timescale 1ns/1ps

module nps_parity_acc #(
  parameter int IDX_W = 12,
  parameter int COL_W = 4
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire logic clear, // Restart accumulation
  input wire logic wordEn, // One data word this cycle
  input wire logic [15:0] wordData, // Data word, upper byte zero if 8-bit
  input wire logic [IDX_W-1:0] wordIdx, // Index of the word in page
  output logic [IDX_W-1:0] rowPar, // Row terms, index bit one
  output logic [IDX_W-1:0] rowParN, // Row terms, index bit zero
  output logic [COL_W-1:0] colPar, // Column terms, position bit one
  output logic [COL_W-1:0] colParN // Column terms, position bit zero
);

  // ****************************************************************
  // Word parity and column selections
  // ****************************************************************
  localparam logic [15:0] COL_SEL [4] = '{nps_pkg::COL_SEL0,
    nps_pkg::COL_SEL1, nps_pkg::COL_SEL2, nps_pkg::COL_SEL3};

  wire logic wordPar;
  assign wordPar = ^wordData;

  // ****************************************************************
  // Row terms: whole-word parity steered by each index bit
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < IDX_W; gi++) begin : gRow
      logic hiReg;
      logic loReg;
      // Each index bit splits the page into two halves
      always_ff @(posedge clk_sys) begin
        if (rst || clear) begin
          hiReg <= 1'b0;
          loReg <= 1'b0;
        end else if (wordEn) begin
          if (wordIdx[gi]) begin
            hiReg <= hiReg ^ wordPar;
          end else begin
            loReg <= loReg ^ wordPar;
          end
        end
      end
      assign rowPar[gi] = hiReg;
      assign rowParN[gi] = loReg;
    end

    // **************************************************************
    // Column terms: bit groups taken over every word
    // **************************************************************
    for (gi = 0; gi < COL_W; gi++) begin : gCol
      logic hiReg;
      logic loReg;
      // Odd/even, pairs, nibbles, bytes
      always_ff @(posedge clk_sys) begin
        if (rst || clear) begin
          hiReg <= 1'b0;
          loReg <= 1'b0;
        end else if (wordEn) begin
          hiReg <= hiReg ^ (^(wordData & COL_SEL[gi]));
          loReg <= loReg ^ (^(wordData & ~COL_SEL[gi]));
        end
      end
      assign colPar[gi] = hiReg;
      assign colParN[gi] = loReg;
    end
  endgenerate

endmodule

// File: test/nps_nand_model.sv
// Behavioural NAND flash page store on the flash side of the bus
`timescale 1ns/1ps

module nps_nand_model (
  input wire logic clk_sys, // System clock
  input wire logic cmdStb, // Command cycle
  input wire logic addrStb, // Address cycle
  input wire logic dataStb, // Data word cycle
  input wire logic hostDrive, // Host owns the bus
  input wire logic [15:0] hostBus, // Host bus value
  output logic [15:0] flashBus // Flash bus value
);
  logic [15:0] mem [0:4223];
  logic progMode = 1'b0;
  logic readMode = 1'b0;
  logic waitAddr = 1'b0;
  int ptr = 0;

  // ****************
  // Page access
  // ****************
  // Only the first address cycle rewinds, so later ones keep the column
  always @(posedge clk_sys) begin
    if (cmdStb) begin
      progMode <= hostBus[7:0] == 8'h80;
      readMode <= hostBus[7:0] == 8'h00;
      waitAddr <= 1'b1;
    end else if (addrStb && waitAddr) begin
      ptr <= 0;
      waitAddr <= 1'b0;
    end else if (dataStb) begin
      if (progMode && hostDrive)
        mem[ptr] <= hostBus;
      ptr <= ptr + 1;
    end
  end

  // Released bus shows the inverse, so stale data never looks valid
  assign flashBus = (readMode && dataStb && !hostDrive) ? mem[ptr] :
                    ~mem[ptr];
endmodule

// File: test/nps_ecc_tb_top.sv
// Self-checking bench for the NAND page code engine
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checked = checked + 1; \
    if ((got) !== (exp)) begin \
      errCount = errCount + 1; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module nps_ecc_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [4:0] regAddr = 5'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic nandCmdStb = 1'b0;
  logic nandAddrStb = 1'b0;
  logic nandDataStb = 1'b0;
  logic nandWide16 = 1'b0;
  logic hostDrive = 1'b1;
  logic [15:0] hostBus = 16'h0000;
  logic [15:0] flashBus;
  logic [15:0] nandBus;
  logic [15:0] img [0:4223];
  logic [15:0] expP;
  logic [15:0] expN;
  logic [31:0] rd;
  int errCount = 0;
  int checked = 0;

  // Whoever owns the shared bus sets its level
  assign nandBus = hostDrive ? hostBus : flashBus;

  nps_ecc_top i_nps_ecc_top (.clk_sys(clk_sys), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .nandCmdStb(nandCmdStb),
    .nandAddrStb(nandAddrStb), .nandDataStb(nandDataStb),
    .nandBus(nandBus), .nandWide16(nandWide16));

  nps_nand_model i_nps_nand_model (.clk_sys(clk_sys), .cmdStb(nandCmdStb),
    .addrStb(nandAddrStb), .dataStb(nandDataStb), .hostDrive(hostDrive),
    .hostBus(hostBus), .flashBus(flashBus));

  // 25 MHz system clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // ****************
  // Bus tasks
  // ****************
  task automatic regWrite(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic regRead(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic chkRegs(input logic [31:0] st, p, n);
    regRead(nps_pkg::OFS_STATUS, rd);
    `CHK(rd, st)
    regRead(nps_pkg::OFS_PARITY, rd);
    `CHK(rd, p)
    regRead(nps_pkg::OFS_NPARITY, rd);
    `CHK(rd, n)
  endtask

  task automatic nandCycle(input logic isCmd, input logic [7:0] v);
    @(posedge clk_sys);
    hostBus <= {8'h00, v};
    if (isCmd)
      nandCmdStb <= 1'b1;
    else
      nandAddrStb <= 1'b1;
    @(posedge clk_sys);
    nandCmdStb <= 1'b0;
    nandAddrStb <= 1'b0;
  endtask

  // Column address zero first; the later address cycles must be ignored
  task automatic startPage(input logic [7:0] code);
    nandCycle(1'b1, code);
    nandCycle(1'b0, 8'h00);
    nandCycle(1'b0, 8'h3c);
    nandCycle(1'b0, 8'h01);
  endtask

  // Strobe held up across the burst so words go back to back
  task automatic burst(input logic rdDir, input int first, input int n);
    for (int k = first; k < first + n; k++) begin
      @(posedge clk_sys);
      nandDataStb <= 1'b1;
      hostDrive <= !rdDir;
      hostBus <= img[k];
    end
    @(posedge clk_sys);
    nandDataStb <= 1'b0;
    hostDrive <= 1'b1;
  endtask

  task automatic flip(input int w, input logic [15:0] m);
    i_nps_nand_model.mem[w] = i_nps_nand_model.mem[w] ^ m;
  endtask

  // ****************
  // Expected code
  // ****************
  task automatic calc(input int sz, input logic w16);
    logic [15:0] wd;
    logic wp;
    expP = 16'h0;
    expN = 16'h0;
    for (int j = 0; j < (512 << sz); j++) begin
      wd = w16 ? img[j] : {8'h00, img[j][7:0]};
      wp = ^wd;
      for (int i = 0; i < 9 + sz; i++)
        if (j[i])
          expP[4 + i] ^= wp;
        else
          expN[4 + i] ^= wp;
      for (int k = 0; k < (w16 ? 4 : 3); k++)
        for (int b = 0; b < 16; b++)
          if (b[k])
            expP[k] ^= wd[b];
          else
            expN[k] ^= wd[b];
    end
  endtask

  // Upper byte is junk in 8-bit mode and must not count
  task automatic programPage(input int sz, input logic w16);
    int nw;
    nw = 512 << sz;
    for (int j = 0; j < nw; j++)
      img[j] = w16 ? 16'(j * 40503 + 7) : {8'ha5, 8'(j * 37 + (j >> 5))};
    calc(sz, w16);
    startPage(nps_pkg::CMD_PAGE_PROGRAM);
    burst(1'b0, 0, nw);
    chkRegs(32'h0, {16'h0, expP}, {16'h0, expN});
    img[nw] = w16 ? expP : {8'h00, expP[7:0]};
    img[nw + 1] = w16 ? expN : {8'h00, expP[15:8]};
    img[nw + 2] = {8'h00, expN[7:0]};
    img[nw + 3] = {8'h00, expN[15:8]};
    burst(1'b0, nw, w16 ? 2 : 4);
    nandCycle(1'b1, 8'h70);
    chkRegs(32'h0, {16'h0, expP}, {16'h0, expN});
  endtask

  task automatic readPage(input int sz, input logic w16);
    startPage(nps_pkg::CMD_PAGE_READ);
    burst(1'b1, 0, (512 << sz) + (w16 ? 2 : 4));
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, over twice the roughly 22k cycles of the sequence
  initial begin
    repeat (50000) @(posedge clk_sys);
    errCount = errCount + 1;
    summarize();
  end

  // ****************
  // Test sequence
  // ****************
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    chkRegs(32'h0, 32'h0, 32'h0);
    regRead(nps_pkg::OFS_MODE, rd);
    `CHK(rd, 32'h0)
    regWrite(nps_pkg::OFS_MODE, 32'hffff_fffe);
    regRead(nps_pkg::OFS_MODE, rd);
    `CHK(rd, 32'h2)
    regRead(nps_pkg::OFS_CTRL, rd);
    `CHK(rd, 32'h0)
    regRead(5'h14, rd);
    `CHK(rd, 32'h0)
    $display("done: register access");
    // Every page size on an 8-bit memory, clean read back
    for (int sz = 0; sz < 4; sz++) begin
      regWrite(nps_pkg::OFS_MODE, 32'(sz));
      programPage(sz, 1'b0);
      readPage(sz, 1'b0);
      chkRegs(32'h0, 32'h0, 32'h0);
    end
    $display("done: page sizes");
    // Error classes on a 512-word page
    regWrite(nps_pkg::OFS_MODE, 32'h0);
    programPage(0, 1'b0);
    flip(300, 16'h0020);
    readPage(0, 1'b0);
    chkRegs(32'h1, {16'h0, 12'd300, 4'd5},
            {19'h0, ~9'd300, 1'b0, ~3'd5});
    flip(300, 16'h0020);
    flip(514, 16'h0040);
    readPage(0, 1'b0);
    chkRegs(32'h2, 32'h0, 32'h40);
    flip(514, 16'h0040);
    flip(10, 16'h0002);
    flip(200, 16'h0040);
    readPage(0, 1'b0);
    regWrite(nps_pkg::OFS_CTRL, 32'h0);
    regRead(nps_pkg::OFS_STATUS, rd);
    `CHK(rd, 32'h5)
    regWrite(nps_pkg::OFS_CTRL, 32'h1);
    chkRegs(32'h0, 32'h0, 32'h0);
    flip(200, 16'h0040);
    $display("done: error classes");
    // A new read or program command wipes earlier results
    for (int c = 0; c < 2; c++) begin
      readPage(0, 1'b0);
      regRead(nps_pkg::OFS_STATUS, rd);
      `CHK(rd, 32'h1)
      nandCycle(1'b1, c ? nps_pkg::CMD_PAGE_PROGRAM : nps_pkg::CMD_PAGE_READ);
      chkRegs(32'h0, 32'h0, 32'h0);
    end
    flip(10, 16'h0002);
    $display("done: command clear");
    // 16-bit memory, 1024-word page
    @(posedge clk_sys);
    nandWide16 <= 1'b1;
    regWrite(nps_pkg::OFS_MODE, 32'h1);
    programPage(1, 1'b1);
    readPage(1, 1'b1);
    chkRegs(32'h0, 32'h0, 32'h0);
    flip(777, 16'h1000);
    readPage(1, 1'b1);
    chkRegs(32'h1, {16'h0, 12'd777, 4'd12},
            {18'h0, ~10'd777, ~4'd12});
    $display("done: wide memory");
    summarize();
  end
endmodule
